//--- pkg/rtc_alarm_map.svh
`ifndef RTC_ALARM_MAP_SVH
`define RTC_ALARM_MAP_SVH
// per-field enable bit inside each alarm compare byte
`define FIELD_EN_BIT 7
// interrupt control register bit positions
`define CTRL_ALARM0_EN_BIT 5
`define CTRL_REPEAT_BIT 7
// pulsed interrupt width
`define PULSE_NS 62500
`define CLK_NS 50
`define PULSE_CYCLES ((`PULSE_NS + `CLK_NS - 1) / `CLK_NS)
`define PULSE_CNT_W 11
`endif

//--- pkg/rtc_alarm_pkg.sv
package rtc_alarm_pkg;
    // time of day / calendar, bcd bytes
    typedef struct packed {
        logic [7:0] weekday;
        logic [7:0] month;
        logic [7:0] date;
        logic [7:0] hours;
        logic [7:0] minutes;
        logic [7:0] seconds;
    } time_fields_t;
    // supply comparator results
    typedef struct packed {
        logic above_reset;   // main supply above reset threshold
        logic above_trip;    // main supply above trip threshold
        logic above_battery; // main supply above battery
    } supply_cmp_t;
    typedef enum logic [1:0] {
        IRQ_IDLE, IRQ_HOLD, IRQ_PULSE
    } irq_state_t;
endpackage : rtc_alarm_pkg

//--- logic/supply_gate.sv
`timescale 1ns/1ps
// turns synchronised supply comparisons and mode bits into access grants
module supply_gate (
    input  wire logic                       clk,
    input  wire logic                       resetn,
    input  wire rtc_alarm_pkg::supply_cmp_t cmp_raw,
    input  wire logic                       bus_in_backup_disable,
    input  wire logic                       switchover_select,
    output logic                            on_battery,
    output logic                            bus_allow,
    output logic                            mem_allow
);
    import rtc_alarm_pkg::*;

    supply_cmp_t s1_reg, s2_reg, s3_reg; // three stage synchroniser
    supply_cmp_t cmp_reg;                // accepted value
    wire         agree;
    wire         legacy;
    wire         batt_mode;

    // analog comparators are asynchronous, so resync before use
    always_ff @(posedge clk) begin
        if (!resetn) begin
            s1_reg  <= '0;
            s2_reg  <= '0;
            s3_reg  <= '0;
            cmp_reg <= '0;
        end else begin
            s1_reg <= cmp_raw;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            if (agree) begin
                cmp_reg <= s3_reg; // [R12]
            end
        end
    end

    assign agree  = (s2_reg == s3_reg);
    assign legacy = switchover_select;
    // standard mode trips at threshold, legacy when main drops below battery
    assign batt_mode = legacy ? !cmp_reg.above_battery : !cmp_reg.above_trip; // [R2] [R3] [R5]
    assign on_battery = batt_mode;
    // bus rules per mode; below reset threshold the bus is always off
    assign bus_allow = cmp_reg.above_reset && // [R1]
                       (!batt_mode ||                                // [R2] [R4]
                        (legacy && !bus_in_backup_disable));         // [R3] [R5]
    // memory access never in backup except legacy with bus enabled
    assign mem_allow = bus_allow && (!batt_mode || !bus_in_backup_disable); // [R5]
endmodule : supply_gate

//--- logic/rtc_alarm_gate.sv
`timescale 1ns/1ps
// Summary of operation
// [R1] no bus answer below reset threshold, ever
// [R2] mode 00: trip switchover, no bus, no memory
// [R3] mode 01: battery switchover, bus above reset
// [R4] mode 10: same as mode 00
// [R5] mode 11: bus only above reset and battery
// [R6] bit 7 enables each alarm compare field
// [R7] host sets alarm enable before interrupts
// [R8] single mode: match at rollover sets flag, irq low
// [R9] pulsed mode: pulse on every match
// [R10] pulsed mode flags each trigger, clear optional
// [R11] single holds low until clear; pulse short
// [R12] supply comparisons enter as synchronised bits
module rtc_alarm_gate (
    input  wire logic                        clk,
    input  wire logic                        resetn,
    input  wire rtc_alarm_pkg::time_fields_t now_time,      // current time
    input  wire logic                        seconds_tick,  // rollover pulse, time now updated
    input  wire rtc_alarm_pkg::time_fields_t alarm0_cmp,    // compare bytes with enables
    input  wire logic                        alarm0_enable,
    input  wire logic                        interrupt_repeat_select,
    input  wire logic                        alarm0_flag_clear, // one-cycle clear pulse
    input  wire rtc_alarm_pkg::supply_cmp_t  supply_cmp,
    input  wire logic                        bus_in_backup_disable,
    input  wire logic                        switchover_select,
    output logic                             alarm0_flag,
    output logic                             irq_freq_out_o,    // always zero when driven
    output logic                             irq_freq_out_oe,   // open drain enable
    output logic                             on_battery,
    output logic                             bus_allow,
    output logic                             mem_allow
);
    import rtc_alarm_pkg::*;
    `include "rtc_alarm_map.svh"

    localparam logic [`PULSE_CNT_W-1:0] PULSE_LEN = `PULSE_CNT_W'(`PULSE_CYCLES);

    irq_state_t                state_reg, state_next;
    logic [`PULSE_CNT_W-1:0]   cnt_reg;
    logic                      flag_reg;
    wire  [5:0]                field_ok;
    wire                       match;
    wire                       trigger;

    // field compare: disabled field always matches
    function automatic logic field_match(input logic [7:0] c, input logic [7:0] t);
        field_match = !c[`FIELD_EN_BIT] || (c[6:0] == t[6:0]); // [R6]
    endfunction : field_match

    // one comparator per time field, bytes laid out as in the time word
    genvar g;
    generate
        for (g = 0; g < 6; g++) begin : g_field
            assign field_ok[g] = field_match(alarm0_cmp[g*8 +: 8], now_time[g*8 +: 8]);
        end
    endgenerate

    // all fields disabled would fire every second; kept as the hardware does
    assign match   = &field_ok;
    // the tick must be one cycle wide; a longer tick would retrigger the pulse
    assign trigger = seconds_tick && match && alarm0_enable; // [R7] [R8] [R9]

    // status flag: set wins over clear
    always_ff @(posedge clk) begin
        if (!resetn) begin
            flag_reg <= 1'b0;
        end else if (trigger) begin
            flag_reg <= 1'b1; // [R8] [R10]
        end else if (alarm0_flag_clear) begin
            flag_reg <= 1'b0;
        end
    end
    assign alarm0_flag = flag_reg;

    // irq pin state machine
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            IRQ_IDLE: begin
                if (trigger) begin
                    state_next = interrupt_repeat_select ? IRQ_PULSE : IRQ_HOLD;
                end
            end
            IRQ_HOLD: begin
                if (alarm0_flag_clear && !trigger) begin
                    state_next = IRQ_IDLE; // [R11]
                end
            end
            IRQ_PULSE: begin
                if (trigger && !interrupt_repeat_select) begin
                    state_next = IRQ_HOLD;
                end else if (cnt_reg == PULSE_LEN - 1'b1 && !trigger) begin
                    state_next = IRQ_IDLE; // [R11]
                end
            end
        endcase
    end

    // state and pulse counter registers
    always_ff @(posedge clk) begin
        if (!resetn) begin
            state_reg <= IRQ_IDLE;
            cnt_reg   <= '0;
        end else begin
            state_reg <= state_next;
            // restart count on every trigger, pulses independent of the flag
            cnt_reg   <= (trigger || state_reg != IRQ_PULSE) ? '0 : cnt_reg + 1'b1; // [R9] [R10]
        end
    end

    assign irq_freq_out_o  = 1'b0;
    assign irq_freq_out_oe = (state_reg != IRQ_IDLE); // [R8] [R9]

    supply_gate u_gate (
        .clk                   (clk),
        .resetn                (resetn),
        .cmp_raw               (supply_cmp),
        .bus_in_backup_disable (bus_in_backup_disable),
        .switchover_select     (switchover_select),
        .on_battery            (on_battery),
        .bus_allow             (bus_allow),
        .mem_allow             (mem_allow)
    );

    // interrupt and flag checks

    // a match at the rollover tick with the enable set always raises the flag
    a_flag_set: assert property (@(posedge clk) disable iff (!resetn) // [R8]
        trigger |=> alarm0_flag)
        else $error("flag not set after trigger");
    // single event output holds until the clear pulse
    a_hold_low: assert property (@(posedge clk) disable iff (!resetn) // [R11]
        (state_reg == IRQ_HOLD && !alarm0_flag_clear) |=> irq_freq_out_oe)
        else $error("single irq released early");
    // first cycles of a pulse are driven
    a_pulse_on: assert property (@(posedge clk) disable iff (!resetn) // [R9]
        (trigger && interrupt_repeat_select) |=> irq_freq_out_oe [*8])
        else $error("pulse too short");
    // the counter never runs past the pulse length
    a_pulse_end: assert property (@(posedge clk) disable iff (!resetn) // [R11]
        (state_reg == IRQ_PULSE) |-> cnt_reg < PULSE_LEN)
        else $error("pulse overran");
    // no flag can rise while the host keeps the alarm disabled
    a_no_trig: assert property (@(posedge clk) disable iff (!resetn) // [R7]
        !alarm0_enable |=> !$rose(alarm0_flag))
        else $error("flag without enable");
    // all compare bytes disabled means every tick matches
    a_field_off: assert property (@(posedge clk) disable iff (!resetn) // [R6]
        (alarm0_cmp == '0) |-> match)
        else $error("disabled fields blocked match");

    // an enabled minutes field that differs must block the match
    a_field_miss: assert property (@(posedge clk) disable iff (!resetn) // [R6]
        (alarm0_cmp.minutes[7] && (alarm0_cmp.minutes[6:0] != now_time.minutes[6:0]))
        |-> !match)
        else $error("enabled field ignored");

    // the clear pulse ends a single event interrupt
    a_clear_release: assert property (@(posedge clk) disable iff (!resetn) // [R11]
        (state_reg == IRQ_HOLD && alarm0_flag_clear && !trigger) |=> !irq_freq_out_oe)
        else $error("single irq stuck after clear");

    // a pulse ends once the counter reaches its last value
    a_pulse_stop: assert property (@(posedge clk) disable iff (!resetn) // [R11]
        (state_reg == IRQ_PULSE && cnt_reg == PULSE_LEN - 1'b1 && !trigger)
        |=> !irq_freq_out_oe)
        else $error("pulse too long");

    // every pulsed match outside the single event hold starts a fresh count
    a_pulse_restart: assert property (@(posedge clk) disable iff (!resetn) // [R9]
        (trigger && interrupt_repeat_select && state_reg != IRQ_HOLD)
        |=> (state_reg == IRQ_PULSE && cnt_reg == '0))
        else $error("pulse not restarted");

    // pulses go on while the flag is still set from before
    a_repeat_flag: assert property (@(posedge clk) disable iff (!resetn) // [R10]
        (trigger && interrupt_repeat_select && alarm0_flag) |=> irq_freq_out_oe)
        else $error("pulse blocked by old flag");

    // the flag moves only on a trigger or a clear
    a_flag_keep: assert property (@(posedge clk) disable iff (!resetn) // [R8]
        (!trigger && !alarm0_flag_clear) |=> $stable(alarm0_flag))
        else $error("flag changed on its own");

    // a clear without a trigger in the same cycle drops the flag
    a_flag_clear: assert property (@(posedge clk) disable iff (!resetn) // [R10]
        (alarm0_flag_clear && !trigger) |=> !alarm0_flag)
        else $error("flag not cleared");

    // supply gating checks

    // nothing passes below the reset threshold
    a_reset_bus: assert property (@(posedge clk) disable iff (!resetn) // [R1]
        !u_gate.cmp_reg.above_reset |-> !bus_allow && !mem_allow)
        else $error("bus open below reset threshold");
    // standard switchover closes everything on battery
    a_std_batt: assert property (@(posedge clk) disable iff (!resetn) // [R2]
        (!switchover_select && on_battery) |-> !bus_allow && !mem_allow)
        else $error("access in standard backup");
    // legacy bus with backup disabled needs main above battery
    a_mode_d: assert property (@(posedge clk) disable iff (!resetn) // [R5]
        (switchover_select && bus_in_backup_disable && bus_allow)
        |-> u_gate.cmp_reg.above_battery)
        else $error("mode d bus on battery");

    // standard switchover follows the trip comparison in both modes
    a_std_switch: assert property (@(posedge clk) disable iff (!resetn) // [R4]
        !switchover_select |-> (on_battery == !u_gate.cmp_reg.above_trip))
        else $error("standard switchover wrong");

    // legacy switchover follows the battery comparison
    a_legacy_switch: assert property (@(posedge clk) disable iff (!resetn) // [R3]
        switchover_select |-> (on_battery == !u_gate.cmp_reg.above_battery))
        else $error("legacy switchover wrong");

    // legacy with bus in backup keeps the bus open above reset
    a_mode_b_bus: assert property (@(posedge clk) disable iff (!resetn) // [R3]
        (switchover_select && !bus_in_backup_disable && u_gate.cmp_reg.above_reset)
        |-> bus_allow)
        else $error("mode b bus closed");

    // legacy with bus in backup lets memory follow the bus
    a_mode_b_mem: assert property (@(posedge clk) disable iff (!resetn) // [R3]
        (switchover_select && !bus_in_backup_disable) |-> (mem_allow == bus_allow))
        else $error("mode b memory gating wrong");

    // no memory access on battery when bus in backup is disabled
    a_mode_d_mem: assert property (@(posedge clk) disable iff (!resetn) // [R5]
        (switchover_select && bus_in_backup_disable && on_battery) |-> !mem_allow)
        else $error("mode d memory on battery");

    // synchroniser accepts the third stage once it agrees with the second
    a_sync_accept: assert property (@(posedge clk) disable iff (!resetn) // [R12]
        (u_gate.s2_reg == u_gate.s3_reg) |=> (u_gate.cmp_reg == $past(u_gate.s3_reg)))
        else $error("agreed comparator value not taken");

    // a disagreeing pair leaves the accepted value alone
    a_sync_hold: assert property (@(posedge clk) disable iff (!resetn) // [R12]
        (u_gate.s2_reg != u_gate.s3_reg) |=> $stable(u_gate.cmp_reg))
        else $error("unsettled comparator value taken");
endmodule : rtc_alarm_gate

//--- tb/host_model.sv
`timescale 1ns/1ps
// stands in for the bus host: owns the alarm enable and the flag clear
module host_model (
    input  wire logic clk,
    input  wire logic want_en,
    input  wire logic want_clr,
    output logic      alarm0_enable = 1'b0,
    output logic      alarm0_flag_clear = 1'b0
);
    // host registers its wishes, so each reaches the gate one cycle later and a clear lasts as long as want_clr
    always @(posedge clk) begin
        alarm0_enable     <= want_en;
        alarm0_flag_clear <= want_clr;
    end
endmodule : host_model

//--- tb/rtc_alarm_gate_tb.sv
`timescale 1ns/1ps
module rtc_alarm_gate_tb;
    import rtc_alarm_pkg::*;
    `include "rtc_alarm_map.svh"
    localparam int PULSE = `PULSE_CYCLES; // pulse width in cycles
    typedef struct packed {logic [4:0] e; logic [4:0] m;} note_t;
    logic clk = 0, resetn = 0, tick = 0, rep = 0, en = 0, clr = 0;
    logic bib = 0, sws = 0, probe = 0, oe_d = 0;
    logic a_en, a_clr, flag, oe, pin_o, onb, bus, mem, ob, bx;
    time_fields_t now_t = '0, cmp = '0;
    supply_cmp_t  sup = '0;
    int bad_count = 0, checks = 0;
    logic [31:0] seed = 32'd27;
    note_t q[$]; // expected results, oldest first
    wire [4:0] got = {oe, flag, onb, bus, mem};
    always #25 clk = ~clk;
    host_model u_host (.clk(clk), .want_en(en), .want_clr(clr),
        .alarm0_enable(a_en), .alarm0_flag_clear(a_clr));
    rtc_alarm_gate u_dut (.clk(clk), .resetn(resetn), .now_time(now_t),
        .seconds_tick(tick), .alarm0_cmp(cmp), .alarm0_enable(a_en),
        .interrupt_repeat_select(rep), .alarm0_flag_clear(a_clr),
        .supply_cmp(sup), .bus_in_backup_disable(bib), .switchover_select(sws),
        .alarm0_flag(flag), .irq_freq_out_o(pin_o), .irq_freq_out_oe(oe),
        .on_battery(onb), .bus_allow(bus), .mem_allow(mem));
    // watcher: a probe or a new interrupt edge consumes the oldest note
    always @(posedge clk) begin
        if (probe || (oe === 1'b1 && oe_d !== 1'b1)) begin
            note_t n;
            checks++;
            if (q.size() == 0) begin
                bad_count++;
                $display("wrong value at %0t: got %h want %h", $time, got, 5'h00);
            end else begin
                n = q.pop_front();
                if ((got & n.m) !== n.e) begin
                    bad_count++;
                    $display("wrong value at %0t: got %h want %h", $time, got & n.m, n.e);
                end
            end
            if (pin_o !== 1'b0) begin
                bad_count++;
                $display("wrong value at %0t: got %h want %h", $time, pin_o, 1'b0);
            end
        end
        oe_d <= oe;
    end
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        return s ^ (s << 5);
    endfunction : xs
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask : cyc
    // note a result and sample it at the coming edge
    task automatic look(input logic [4:0] e, input logic [4:0] m);
        q.push_back('{e, m});
        probe = 1;
        cyc(1);
        probe = 0;
    endtask : look
    // one rollover tick; a nonzero mask means an interrupt edge is due
    task automatic fire(input logic [4:0] m);
        if (m != 0) q.push_back('{m, m});
        tick = 1;
        cyc(1);
        tick = 0;
        cyc(2);
        if (q.size() != 0) begin
            bad_count++;
            $display("wrong value at %0t: got %h want %h", $time, 5'h00, q[0].e);
            q.delete();
        end
    endtask : fire
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : give_verdict
    initial begin
        cyc(5);
        resetn = 1;
        look(5'b00100, 5'b11111);
        // random supply states under every mode pair; the filter needs 4 cycles
        for (int i = 0; i < 32; i++) begin
            seed = xs(seed);
            {bib, sws} = i[1:0];
            sup = seed[2:0];
            sup.above_trip |= sup.above_reset; // reset threshold sits above trip
            cyc(6);
            ob = sws ? !sup.above_battery : !sup.above_trip;
            bx = sup.above_reset & (!(bib & sws) | sup.above_battery);
            look({2'b00, ob, bx, bx & (!ob | (sws & !bib))}, 5'b00111);
        end
        $display("supply gating test done");
        sup = '1;
        {bib, sws} = 2'b00;
        cmp = {8'h00, 8'h81, 8'h81, 8'h91, 8'hb0, 8'h00};
        now_t = {8'h05, 8'h01, 8'h01, 8'h11, 8'h31, 8'h00};
        en = 1;
        cyc(6);
        fire(0);
        look(5'b00000, 5'b11000);
        now_t.minutes = 8'h30;
        en = 0;
        cyc(3);
        fire(0);
        look(5'b00000, 5'b11000);
        en = 1;
        cyc(3);
        fire(5'b11000);
        cyc(3000);
        look(5'b11000, 5'b11000);
        clr = 1;
        cyc(1);
        clr = 0;
        cyc(3);
        look(5'b00000, 5'b11000);
        $display("single event test done");
        rep = 1;
        fire(5'b11000);
        cyc(PULSE - 5);
        look(5'b11000, 5'b11000);
        cyc(5);
        look(5'b01000, 5'b11000);
        fire(5'b11000);
        $display("pulsed test done");
        // reset in mid pulse: every output returns to its reset value
        resetn = 0;
        cyc(5);
        resetn = 1;
        look(5'b00100, 5'b11111);
        $display("reset test done");
        give_verdict();
    end
endmodule : rtc_alarm_gate_tb
